// *** hw/gbc_pkg.sv ***
/*
 Package for the gapped burst clock generator: register offsets, field
 positions, reset values and shared types.
 Assumes a single system clock; divider outputs arrive as asynchronous levels.
*/
package gbc_pkg;
   localparam int          NUM_OUT          = 6;
   localparam int          NUM_CH           = 2;
   localparam logic [15:0] ADDR_GAP_CH0     = 16'h10D2;
   localparam logic [15:0] ADDR_BURST_CH0   = 16'h10D3;
   localparam logic [15:0] ADDR_GATE_CH0    = 16'h10D4;
   localparam logic [15:0] ADDR_RETIME_CH0  = 16'h10D6;
   localparam logic [15:0] ADDR_GAP_CH1     = 16'h14D2;
   localparam logic [15:0] ADDR_BURST_CH1   = 16'h14D3;
   localparam logic [15:0] ADDR_GATE_CH1    = 16'h14D4;
   localparam logic [15:0] ADDR_RETIME_CH1  = 16'h14D6;
   localparam logic [15:0] ADDR_REQ_CH0     = 16'h2101;
   localparam logic [15:0] ADDR_REQ_CH1     = 16'h2201;
   localparam logic [15:0] ADDR_STAT_CH0    = 16'h2102;
   localparam logic [15:0] ADDR_STAT_CH1    = 16'h2202;
   localparam int          LEN_MSB          = 5;
   localparam int          MODE_BIT         = 6;
   localparam int          RETIME_BIT       = 0;
   localparam int          REQ_BIT          = 0;
   localparam int          SRC_BIT          = 1;
   localparam int          RETIME_LATENCY   = 3;
   localparam logic [7:0]  RST_REG          = 8'h00;

   typedef struct packed {
      logic [7:0] gap;
      logic [5:0] clk_len;
      logic       periodic;
      logic       retime;
      logic       use_pin;
      logic       req;
   } gbc_cfg_s;

   typedef enum logic [1:0] {
      GBC_IDLE  = 2'b00,
      GBC_CLK   = 2'b01,
      GBC_GAP   = 2'b10,
      GBC_STALL = 2'b11
   } gbc_state_e;
endpackage

// *** hw/gbc_top.sv ***
/*
 Gapped burst clock generator, two channels of six gated outputs each.
 Assumes divider clocks and the pin trigger are asynchronous levels that are
 much slower than CLOCK (divide ratio at least eight), so each divider cycle
 is seen as one rising edge after a two flop synchroniser.
*/
`timescale 1ns/1ns

module gbc_top #(
   parameter int NOUT = gbc_pkg::NUM_OUT
) (
   input  wire logic                  CLOCK,
   input  wire logic                  RST_N,
   input  wire logic [15:0]           ADDR,
   input  wire logic [7:0]            WDATA,
   input  wire logic                  WR,
   input  wire logic                  RD,
   output logic      [7:0]            RDATA,
   input  wire logic [NOUT-1:0]       DIV_CLK_CH0,
   input  wire logic [NOUT-1:0]       DIV_CLK_CH1,
   input  wire logic [NOUT*8-1:0]     PHASE_CH0,
   input  wire logic [NOUT*8-1:0]     PHASE_CH1,
   input  wire logic [NOUT-1:0]       PRBS_EN_CH0,
   input  wire logic [NOUT-1:0]       PRBS_EN_CH1,
   input  wire logic [1:0]            MULTIFUNCTION_PIN,
   output logic      [NOUT-1:0]       GATED_CLK_CH0,
   output logic      [NOUT-1:0]       GATED_CLK_CH1
);
   logic [7:0]      rdata_ff;
   logic [NOUT-1:0] gate_ff [2];
   gbc_pkg::gbc_cfg_s cfg_ff [2];
   logic [NOUT-1:0] out_w [2];
   logic [7:0]      stat_w [2];

   wire logic [NOUT-1:0]   div_in   [2];
   wire logic [NOUT*8-1:0] phase_in [2];
   wire logic [NOUT-1:0]   prbs_in  [2];
   assign div_in[0]   = DIV_CLK_CH0;
   assign div_in[1]   = DIV_CLK_CH1;
   assign phase_in[0] = PHASE_CH0;
   assign phase_in[1] = PHASE_CH1;
   assign prbs_in[0]  = PRBS_EN_CH0;
   assign prbs_in[1]  = PRBS_EN_CH1;

   function automatic logic [15:0] base_off(input int ch,
                                            input logic [15:0] a0,
                                            input logic [15:0] a1);
      base_off = (ch == 0) ? a0 : a1;
   endfunction

   genvar c;
   generate
      for (c = 0; c < 2; c++) begin : g_ch
         wire logic sel_gap    = ADDR == base_off(c, gbc_pkg::ADDR_GAP_CH0,
                                                  gbc_pkg::ADDR_GAP_CH1);
         wire logic sel_burst  = ADDR == base_off(c, gbc_pkg::ADDR_BURST_CH0,
                                                  gbc_pkg::ADDR_BURST_CH1);
         wire logic sel_gate   = ADDR == base_off(c, gbc_pkg::ADDR_GATE_CH0,
                                                  gbc_pkg::ADDR_GATE_CH1);
         wire logic sel_retime = ADDR == base_off(c,
                                   gbc_pkg::ADDR_RETIME_CH0,
                                   gbc_pkg::ADDR_RETIME_CH1);
         wire logic sel_req    = ADDR == base_off(c, gbc_pkg::ADDR_REQ_CH0,
                                                  gbc_pkg::ADDR_REQ_CH1);
         wire logic sel_stat   = ADDR == base_off(c, gbc_pkg::ADDR_STAT_CH0,
                                                  gbc_pkg::ADDR_STAT_CH1);

         always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N) begin
               cfg_ff[c]  <= '0;
               gate_ff[c] <= '0;
            end else if (WR) begin
               if (sel_gap)
                  cfg_ff[c].gap <= WDATA;
               if (sel_burst) begin
                  cfg_ff[c].clk_len  <= WDATA[gbc_pkg::LEN_MSB:0];
                  cfg_ff[c].periodic <= WDATA[gbc_pkg::MODE_BIT];
               end
               if (sel_gate)
                  gate_ff[c] <= WDATA[NOUT-1:0];
               if (sel_retime)
                  cfg_ff[c].retime <= WDATA[gbc_pkg::RETIME_BIT];
               if (sel_req) begin
                  cfg_ff[c].req     <= WDATA[gbc_pkg::REQ_BIT];
                  cfg_ff[c].use_pin <= WDATA[gbc_pkg::SRC_BIT];
               end
            end
         end

         wire logic [7:0] rd_c =
            sel_gap    ? cfg_ff[c].gap :
            sel_burst  ? {1'b0, cfg_ff[c].periodic, 
                          cfg_ff[c].clk_len} :
            sel_gate   ? 8'(gate_ff[c]) :
            sel_retime ? {7'h00, cfg_ff[c].retime} :
            sel_req    ? {6'h00, cfg_ff[c].use_pin, cfg_ff[c].req} :
            sel_stat   ? stat_w[c] : 8'h00;

         gbc_chan #(.NOUT(NOUT)) u_chan (
            .CLOCK    (CLOCK),
            .RST_N    (RST_N),
            .CFG      (cfg_ff[c]),
            .GATE_EN  (gate_ff[c] & ~prbs_in[c]),
            .DIV_CLK  (div_in[c]),
            .PHASE    (phase_in[c]),
            .PIN      (MULTIFUNCTION_PIN[c]),
            .OUT      (out_w[c]),
            .STATUS   (stat_w[c])
         );
      end
   endgenerate

   wire logic [7:0] rd_mux = g_ch[0].rd_c | g_ch[1].rd_c;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N)
         rdata_ff <= gbc_pkg::RST_REG;
      else if (RD)
         rdata_ff <= rd_mux;
      else
         rdata_ff <= 8'h00;
   end

   assign RDATA         = rdata_ff;
   assign GATED_CLK_CH0 = out_w[0];
   assign GATED_CLK_CH1 = out_w[1];

   property p_rd_idle;
      @(posedge CLOCK) disable iff (!RST_N)
         !$past(RD) |-> RDATA == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside read");
endmodule

// One channel: trigger path, retimer and per output generators
module gbc_chan #(
   parameter int NOUT = 6
) (
   input  wire logic                CLOCK,
   input  wire logic                RST_N,
   input  wire gbc_pkg::gbc_cfg_s   CFG,
   input  wire logic [NOUT-1:0]     GATE_EN,
   input  wire logic [NOUT-1:0]     DIV_CLK,
   input  wire logic [NOUT*8-1:0]   PHASE,
   input  wire logic                PIN,
   output logic      [NOUT-1:0]     OUT,
   output logic      [7:0]          STATUS
);
   logic [NOUT-1:0] div_s1_ff;
   logic [NOUT-1:0] div_s2_ff;
   logic [NOUT-1:0] div_d_ff;
   logic            pin_s1_ff;
   logic            pin_s2_ff;
   logic            trig_d_ff;
   logic            trig_e_d_ff;
   logic            armed_ff;
   logic [1:0]      rt_cnt_ff;
   logic            rt_level_ff;
   logic [2:0]      slow_ff;

   default clocking dc @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   wire logic [NOUT-1:0] div_rise = div_s2_ff & ~div_d_ff;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         div_s1_ff <= '0;
         div_s2_ff <= '0;
         div_d_ff  <= '0;
         pin_s1_ff <= 1'b0;
         pin_s2_ff <= 1'b0;
      end else begin
         div_s1_ff <= DIV_CLK;
         div_s2_ff <= div_s1_ff;
         div_d_ff  <= div_s2_ff;
         pin_s1_ff <= PIN;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   wire logic trig_raw = CFG.use_pin ? pin_s2_ff : CFG.req;
   wire logic trig_rise = trig_raw & ~trig_d_ff;

   function automatic logic [2:0] pick_slow(input logic [NOUT*8-1:0] ph,
                                            input logic [NOUT-1:0] en);
      logic [7:0] best;
      best = 8'h00;
      pick_slow = 3'h0;
      for (int i = 0; i < NOUT; i++) begin
         if (en[i] && ph[i*8 +: 8] >= best) begin
            best = ph[i*8 +: 8];
            pick_slow = 3'(i);
         end
      end
   endfunction

   wire logic slow_tick = div_rise[slow_ff];
   wire logic rt_fire = armed_ff && slow_tick &&
                        rt_cnt_ff == 2'(gbc_pkg::RETIME_LATENCY - 1);

   wire logic trig_eff    = CFG.retime ? rt_level_ff : trig_raw;
   wire logic trig_e_rise = trig_eff & ~trig_e_d_ff;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         trig_d_ff   <= 1'b0;
         trig_e_d_ff <= 1'b0;
         armed_ff    <= 1'b0;
         rt_cnt_ff   <= 2'h0;
         rt_level_ff <= 1'b0;
         slow_ff     <= 3'h0;
      end else begin
         trig_d_ff   <= trig_raw;
         trig_e_d_ff <= trig_eff;
         slow_ff     <= pick_slow(PHASE, GATE_EN);
         if (rt_fire) begin
            armed_ff    <= 1'b0;
            rt_cnt_ff   <= 2'h0;
            // Short requests still give one event
            rt_level_ff <= 1'b1;
         end else if (armed_ff && slow_tick) begin
            rt_cnt_ff <= rt_cnt_ff + 2'h1;
         end else if (trig_rise && !armed_ff) begin
            armed_ff  <= 1'b1;
            rt_cnt_ff <= 2'h0;
         end
         if (!trig_raw && !armed_ff)
            rt_level_ff <= 1'b0;
      end
   end

   genvar g;
   wire logic [7:0]      clk_cnt = {2'h0, CFG.clk_len};
   wire logic [NOUT-1:0] out_v;

   function automatic logic [7:0] gap_cycles(input logic [7:0] gap);
      gap_cycles = (gap == 8'h00) ? 8'h01 : gap;
   endfunction

   property p_retime_fire;
      rt_fire |=> rt_level_ff;
   endproperty
   a_retime_fire: assert property (p_retime_fire)
      else $error("retimed trigger missing after third tick");
   c_retime_fire: cover property (rt_fire);

   generate
      for (g = 0; g < NOUT; g++) begin : g_gen
         gbc_pkg::gbc_state_e state_ff;
         gbc_pkg::gbc_state_e nxt_state;
         logic [7:0]          cnt_ff;
         logic [7:0]          nxt_cnt;
         logic                on_ff;
         logic                nxt_on;
         logic                out_ff;
         logic                pend_ff;
         wire logic tick    = div_rise[g];
         wire logic idle    = state_ff == gbc_pkg::GBC_IDLE;
         wire logic consume = tick && idle && GATE_EN[g];
         wire logic start   = CFG.periodic ? trig_eff
                                           : (pend_ff || trig_e_rise);
         wire logic run     = !CFG.periodic || trig_eff;
         // An edge between ticks waits here for the next tick in GBC_IDLE
         wire logic nxt_pend = !consume &&
                               (pend_ff || (!CFG.periodic && trig_e_rise));
         always_comb begin
            nxt_state = state_ff;
            nxt_cnt   = cnt_ff;
            nxt_on    = on_ff;
            if (tick) begin
               nxt_on = 1'b0;
               if (!GATE_EN[g])
                  nxt_state = gbc_pkg::GBC_IDLE;
               else if (run) begin
                  case (state_ff)
                     gbc_pkg::GBC_IDLE: begin
                        if (start && clk_cnt != 8'h00) begin
                           nxt_state = gbc_pkg::GBC_CLK;
                           nxt_cnt   = clk_cnt - 8'h01;
                           nxt_on    = 1'b1;
                        end else if (start && CFG.periodic) begin
                           nxt_state = gbc_pkg::GBC_GAP;
                           nxt_cnt   = gap_cycles(CFG.gap) - 8'h01;
                        end
                     end
                     gbc_pkg::GBC_CLK: begin
                        if (cnt_ff != 8'h00) begin
                           nxt_cnt = cnt_ff - 8'h01;
                           nxt_on  = 1'b1;
                        end else if (CFG.periodic) begin
                           nxt_state = gbc_pkg::GBC_GAP;
                           nxt_cnt   = gap_cycles(CFG.gap) - 8'h01;
                        end else begin
                           nxt_state = gbc_pkg::GBC_IDLE;
                        end
                     end
                     gbc_pkg::GBC_GAP: begin
                        if (cnt_ff != 8'h00) begin
                           nxt_cnt = cnt_ff - 8'h01;
                        end else if (clk_cnt != 8'h00) begin
                           nxt_state = gbc_pkg::GBC_CLK;
                           nxt_cnt   = clk_cnt - 8'h01;
                           nxt_on    = 1'b1;
                        end else begin
                           nxt_cnt = gap_cycles(CFG.gap) - 8'h01;
                        end
                     end
                     default: nxt_state = gbc_pkg::GBC_IDLE;
                  endcase
               end
            end
         end

         always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N) begin
               state_ff <= gbc_pkg::GBC_IDLE;
               cnt_ff   <= 8'h00;
               on_ff    <= 1'b0;
               out_ff   <= 1'b0;
               pend_ff  <= 1'b0;
            end else begin
               state_ff <= nxt_state;
               cnt_ff   <= nxt_cnt;
               on_ff    <= nxt_on;
               out_ff   <= nxt_on & div_s2_ff[g];
               pend_ff  <= nxt_pend;
            end
         end
         assign out_v[g] = out_ff;

         property p_tick_only;
            !tick |=> on_ff == $past(on_ff);
         endproperty
         a_tick_only: assert property (p_tick_only)
            else $error("pattern moved between divider ticks");
         property p_gate_off;
            tick && !GATE_EN[g] |=> !on_ff;
         endproperty
         a_gate_off: assert property (p_gate_off)
            else $error("ungated output produced a pulse");
         property p_zero_len;
            idle && CFG.clk_len == 6'h00 |=> !on_ff;
         endproperty
         a_zero_len: assert property (p_zero_len)
            else $error("zero clock segment produced a pulse");
         property p_stall_low;
            tick && CFG.periodic && !trig_eff |=> !on_ff;
         endproperty
         a_stall_low: assert property (p_stall_low)
            else $error("periodic output not stalled low");
         property p_burst_wait;
            tick && idle && !CFG.periodic && !start |=> !on_ff;
         endproperty
         a_burst_wait: assert property (p_burst_wait)
            else $error("burst started without a trigger edge");
         c_burst_run: cover property (idle ##1 state_ff == gbc_pkg::GBC_CLK);
         c_gap_run: cover property (state_ff == gbc_pkg::GBC_GAP);
      end
   endgenerate

   assign STATUS = {6'h00, armed_ff, trig_eff};
   assign OUT    = out_v;
endmodule

// *** sim/gbc_div_model.sv ***
/*
 Divider output clocks for both channels of the gapped clock bench.
 Assumes the generator samples these free running levels with CLOCK.
*/
`timescale 1ns/1ns
module gbc_div_model #(
   parameter int NOUT = 6
) (
   output logic [NOUT-1:0] DIV_CLK_CH0,
   output logic [NOUT-1:0] DIV_CLK_CH1
);
   initial begin
      DIV_CLK_CH0 = '0;
      DIV_CLK_CH1 = '0;
   end
   always #1650 DIV_CLK_CH0 = ~DIV_CLK_CH0;
   always #2050 DIV_CLK_CH1 = ~DIV_CLK_CH1;
endmodule

// *** sim/tb_top.sv ***
/*
 Self-checking bench for the gapped burst clock generator.
 Assumes the divider model runs free and every gate bit is set.
*/
`timescale 1ns/1ns
module tb_top;
   localparam int P0 = 33;
   localparam int P1 = 41;
   localparam int N  = gbc_pkg::NUM_OUT;
   logic           CLOCK = 1'h0;
   logic           RST_N = 1'h0;
   logic [15:0]    addr  = 16'h0000;
   logic [7:0]     wdata = 8'h00;
   logic           wr_en = 1'h0;
   logic           rd_en = 1'h0;
   logic [7:0]     rdata, d;
   logic [N-1:0]   div0, div1, out0, out1, q0, q1;
   logic [N*8-1:0] ph = '0;
   logic [1:0]     pin = 2'h0;
   logic [7:0]     c0, c5, c1;
   logic           clr = 1'h0;
   int             num_errors = 0;
   int             checks_done = 0;
   int             t;

   always #50 CLOCK = ~CLOCK;
   gbc_div_model #(.NOUT(N)) i_gbc_div_model (.DIV_CLK_CH0(div0),
      .DIV_CLK_CH1(div1));
   gbc_top #(.NOUT(N)) i_gbc_top (.CLOCK(CLOCK), .RST_N(RST_N),
      .ADDR(addr), .WDATA(wdata), .WR(wr_en), .RD(rd_en), .RDATA(rdata),
      .DIV_CLK_CH0(div0), .DIV_CLK_CH1(div1), .PHASE_CH0(ph),
      .PHASE_CH1(ph), .PRBS_EN_CH0('0), .PRBS_EN_CH1('0),
      .MULTIFUNCTION_PIN(pin), .GATED_CLK_CH0(out0), .GATED_CLK_CH1(out1));

   // Rising edges of sampled outputs, one per divider cycle
   always @(posedge CLOCK) begin
      q0 <= out0;
      q1 <= out1;
      c0 <= clr ? 8'h00 : c0 + 8'(out0[0] & ~q0[0]);
      c5 <= clr ? 8'h00 : c5 + 8'(out0[N-1] & ~q0[N-1]);
      c1 <= clr ? 8'h00 : c1 + 8'(out1[0] & ~q1[0]);
   end

   task automatic close_out;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge CLOCK);
      addr  <= a;
      wdata <= v;
      wr_en <= 1'h1;
      @(posedge CLOCK);
      wr_en <= 1'h0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge CLOCK);
      addr  <= a;
      rd_en <= 1'h1;
      @(posedge CLOCK);
      rd_en <= 1'h0;
      #1 v = rdata;
   endtask

   task automatic wait_c(input int n);
      repeat (n) @(posedge CLOCK);
   endtask

   task automatic zero;
      @(posedge CLOCK);
      clr <= 1'h1;
      @(posedge CLOCK);
      clr <= 1'h0;
   endtask

   task automatic shot(input int len, input int gap, input logic rt);
      wr(gbc_pkg::ADDR_GAP_CH0, 8'(gap));
      wr(gbc_pkg::ADDR_BURST_CH0, 8'(len));
      wr(gbc_pkg::ADDR_RETIME_CH0, {7'h00, rt});
      zero();
      wr(gbc_pkg::ADDR_REQ_CH0, 8'h01);
      t = 0;
      // Bounded wait for the first pulse; slow start means retimed
      while (c0 == 8'h00 && t < 5 * P0) begin
         @(posedge CLOCK);
         t++;
      end
      wr(gbc_pkg::ADDR_REQ_CH0, 8'h00);
      if (len > 0) chk("latency", {7'h00, rt}, {7'h00, t > 3 * P0 / 2});
      wait_c((len + gap + 8) * P0);
      chk("burst count", 8'(len), c0);
      chk("other output", 8'(len), c5);
   endtask

   task automatic per(input int len, input int gap);
      wr(gbc_pkg::ADDR_GAP_CH0, 8'(gap));
      wr(gbc_pkg::ADDR_BURST_CH0, 8'h40 | 8'(len));
      wr(gbc_pkg::ADDR_RETIME_CH0, 8'h00);
      zero();
      wr(gbc_pkg::ADDR_REQ_CH0, 8'h01);
      wait_c(3 * (len + gap + 1) * P0);
      wr(gbc_pkg::ADDR_REQ_CH0, 8'h00);
      chk("repeats", 8'h01, 8'(c0 > len));
      wait_c((len + gap + 4) * P0);
      zero();
      wait_c(4 * P0);
      chk("stopped", 8'h00, c0);
   endtask

   initial begin
      void'($urandom(32'h042d5f6a));
      ph = (N*8)'({$urandom, $urandom});
      repeat (6) @(posedge CLOCK);
      RST_N <= 1'h1;
      rd(gbc_pkg::ADDR_RETIME_CH0, d);
      chk("retime reset", gbc_pkg::RST_REG, d);
      for (int i = 0; i < 4; i++) begin
         t = $urandom;
         wr(gbc_pkg::ADDR_GAP_CH1, 8'(t));
         rd(gbc_pkg::ADDR_GAP_CH1, d);
         chk("gap rw", 8'(t), d);
      end
      wr(gbc_pkg::ADDR_GATE_CH0, 8'hFF);
      wr(gbc_pkg::ADDR_GATE_CH1, 8'hFF);
      shot(6, 10, 1'h0);
      shot(0, 5, 1'h0);
      shot(3, 0, 1'h0);
      shot(63, 0, 1'h0);
      shot(4, 3, 1'h1);
      for (int i = 0; i < 4; i++) begin
         shot(1 + $urandom % 8, $urandom % 16, 1'($urandom));
      end
      per(3, 2);
      per(1, 0);
      wr(gbc_pkg::ADDR_GAP_CH1, 8'h04);
      wr(gbc_pkg::ADDR_BURST_CH1, 8'h05);
      wr(gbc_pkg::ADDR_REQ_CH1, 8'h02);
      zero();
      pin <= 2'h3;
      wait_c(2 * P1);
      pin <= 2'h0;
      wait_c(12 * P1);
      chk("pin burst", 8'h05, c1);
      close_out();
   end

   initial begin
      repeat (100000) @(posedge CLOCK);
      num_errors++;
      close_out();
   end
endmodule
